// ==== sfr_pkg.sv ====
// shared constants and types for the synchronous fifo with flags
package sfr_pkg;
    localparam int DATA_W = 9;
    localparam int DEPTH  = 16;
    localparam int PTR_W  = 4;
    localparam int CNT_W  = PTR_W + 1;

    localparam logic [CNT_W-1:0]  DEPTH_C       = 5'h10;
    localparam logic [PTR_W-1:0]  AE_OFF_RST    = 4'h2;
    localparam logic [PTR_W-1:0]  AF_OFF_RST    = 4'h2;
    localparam logic [DATA_W-1:0] DOUT_RST      = 9'h000;
    localparam logic [CNT_W-1:0]  PTR_RST       = 5'h00;

    typedef enum logic
    {
        SFR_MODE_PUSH2 = 1'b0,
        SFR_MODE_LOAD  = 1'b1
    } sfr_mode_e;

    typedef struct packed
    {
        logic [PTR_W-1:0] ae_off;
        logic [PTR_W-1:0] af_off;
    } sfr_cfg_s;

    typedef struct packed
    {
        logic empty_n;
        logic full_n;
        logic almost_empty_n;
        logic almost_full_n;
    } sfr_flags_s;
endpackage

// ==== sfr_top.sv ====
// fifo buffer with gray pointers, and the flag, mode and offset logic around it
// Overview of operation
// - clocks may keep running during reset; nothing needs them stopped.
// - after reset data pins low if output enable is 0, released if 1.
// - second_push_en_or_load held high in reset makes it a second write enable.
// - held low in reset makes it the offset register load enable.
// - first word appears on the output the read cycle after empty_n rises.
// - first-word latency at the empty boundary is at most one clock plus skew.
// - almost-empty change follows the causing read edge directly, with no slip.
// - almost-full change follows the causing write edge directly, with no slip.
// - almost_empty_n low once a read leaves offset n minus one words or fewer.
// - almost_full_n low once a write reaches full minus m plus one words.
// - almost-full threshold is taken against the configured depth.
// - full_n rises at the clock edge of the freeing read itself.
// - empty_n rises at the clock edge of the filling write itself.
`timescale 1ns/1ps

module sfr_buf
    import sfr_pkg::*;
#(
    parameter int W = DATA_W,
    parameter int D = DEPTH
)(
    input  wire logic                 clk,
    input  wire logic                 resetn,
    input  wire logic                 in_valid,
    output logic                      in_ready,
    input  wire logic [W-1:0]         in_data,
    output logic                      out_valid,
    input  wire logic                 out_ready,
    output logic [W-1:0]              out_data,
    output logic [$clog2(D):0]        level
);
    localparam int AW = $clog2(D);

    logic [W-1:0]  mem_q [D];
    logic [W-1:0]  mem_d [D];
    logic [AW:0]   wg_q;
    logic [AW:0]   wg_d;
    logic [AW:0]   rg_q;
    logic [AW:0]   rg_d;
    logic [AW:0]   wb;
    logic [AW:0]   rb;
    logic          push;
    logic          pop;

    function automatic logic [AW:0] g2b(input logic [AW:0] g);
        logic [AW:0] b;
        b[AW] = g[AW];
        for (int i = AW - 1; i >= 0; i--)
        begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    function automatic logic [AW:0] b2g(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction

    always_comb
    begin
        wb        = g2b(wg_q);
        rb        = g2b(rg_q);
        level     = wb - rb;
        in_ready  = (level != D[AW:0]) || (D == 0);
        out_valid = (level != '0);
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        out_data  = mem_q[rb[AW-1:0]];
        wg_d      = push ? b2g(wb + 1'b1) : wg_q;
        rg_d      = pop  ? b2g(rb + 1'b1) : rg_q;
    end

    for (genvar e = 0; e < D; e++)
    begin : g_ent
        always_comb
        begin
            mem_d[e] = (push && (wb[AW-1:0] == AW'(e))) ? in_data : mem_q[e];
        end
        always_ff @(posedge clk)
        begin
            mem_q[e] <= mem_d[e];
        end
    end

    // asynchronous reset only on pointers; clocks may run throughout
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wg_q <= '0;
            rg_q <= '0;
        end
        else
        begin
            wg_q <= wg_d;
            rg_q <= rg_d;
        end
    end
endmodule // sfr_buf

module sfr_top
    import sfr_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic              push_en_n,
    input  wire logic              second_push_en_or_load,
    input  wire logic [DATA_W-1:0] wr_data,
    output logic                   wr_ready,
    input  wire logic              pop_en_n,
    input  wire logic              out_en_n,
    output logic [DATA_W-1:0]      rd_data_o,
    output logic [DATA_W-1:0]      rd_data_oe_n,
    output logic                   empty_n_flag,
    output logic                   full_n_flag,
    output logic                   almost_empty_n_flag,
    output logic                   almost_full_n_flag,
    output logic                   load_mode
);
    sfr_mode_e          mode_q;
    sfr_mode_e          mode_d;
    logic               armed_q;
    logic               armed_d;
    logic               sel_af_q;
    logic               sel_af_d;
    sfr_cfg_s           cfg_q;
    sfr_cfg_s           cfg_d;
    sfr_flags_s         flg_q;
    sfr_flags_s         flg_d;
    logic [DATA_W-1:0]  dout_q;
    logic [DATA_W-1:0]  dout_d;
    logic               in_valid;
    logic               in_ready;
    logic               out_valid;
    logic               out_ready;
    logic [DATA_W-1:0]  head;
    logic [CNT_W-1:0]   level;
    logic [CNT_W-1:0]   lvl_next;
    logic               load_wr;

    sfr_buf #(
        .W (DATA_W),
        .D (DEPTH)
    ) u_buf (
        .clk       (clk),
        .resetn    (resetn),
        .in_valid  (in_valid),
        .in_ready  (in_ready),
        .in_data   (wr_data),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (head),
        .level     (level)
    );

    always_comb
    begin
        // mode is caught at the first edge after release; writes wait for it
        mode_d  = armed_q ? mode_q
                : (second_push_en_or_load ? SFR_MODE_PUSH2 : SFR_MODE_LOAD);
        armed_d = 1'b1;
        load_wr = armed_q && (mode_q == SFR_MODE_LOAD) && !push_en_n
                  && !second_push_en_or_load;
        in_valid = armed_q && !push_en_n && second_push_en_or_load;
        wr_ready = armed_q && in_ready;
        // pop only while the registered empty flag says data is there
        out_ready = !pop_en_n && flg_q.empty_n;
        sel_af_d  = load_wr ? !sel_af_q : sel_af_q;
        cfg_d     = cfg_q;
        if (load_wr && !sel_af_q)
        begin
            cfg_d.ae_off = wr_data[PTR_W-1:0];
        end
        if (load_wr && sel_af_q)
        begin
            cfg_d.af_off = wr_data[PTR_W-1:0];
        end
        dout_d   = (out_ready && out_valid) ? head : dout_q;
        lvl_next = level + CNT_W'(in_valid && in_ready)
                         - CNT_W'(out_ready && out_valid);
        // one clock, so every flag follows the causing edge directly
        flg_d.empty_n        = (lvl_next != '0);
        flg_d.full_n         = (lvl_next != DEPTH_C);
        flg_d.almost_empty_n = (lvl_next >= {1'b0, cfg_q.ae_off});
        flg_d.almost_full_n  = (lvl_next <= (DEPTH_C - {1'b0, cfg_q.af_off}));
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            mode_q   <= SFR_MODE_PUSH2;
            armed_q  <= 1'b0;
            sel_af_q <= 1'b0;
            cfg_q    <= '{ae_off: AE_OFF_RST, af_off: AF_OFF_RST};
            flg_q    <= '{empty_n: 1'b0, full_n: 1'b1,
                          almost_empty_n: 1'b0, almost_full_n: 1'b1};
            dout_q   <= DOUT_RST;
        end
        else
        begin
            mode_q   <= mode_d;
            armed_q  <= armed_d;
            sel_af_q <= sel_af_d;
            cfg_q    <= cfg_d;
            flg_q    <= flg_d;
            dout_q   <= dout_d;
        end
    end

    assign rd_data_o           = dout_q;
    assign rd_data_oe_n        = {DATA_W{out_en_n}};
    assign empty_n_flag        = flg_q.empty_n;
    assign full_n_flag         = flg_q.full_n;
    assign almost_empty_n_flag = flg_q.almost_empty_n;
    assign almost_full_n_flag  = flg_q.almost_full_n;
    assign load_mode           = (mode_q == SFR_MODE_LOAD);
endmodule // sfr_top

// ==== sfr_top_assertions.sv ====
// concurrent checks on the flagged fifo ports
`timescale 1ns/1ps
module sfr_chk
    import sfr_pkg::*;
(
    input wire logic              clk,
    input wire logic              resetn,
    input wire logic              push_en_n,
    input wire logic              second_push_en_or_load,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic              wr_ready,
    input wire logic              pop_en_n,
    input wire logic              out_en_n,
    input wire logic [DATA_W-1:0] rd_data_o,
    input wire logic [DATA_W-1:0] rd_data_oe_n,
    input wire logic              empty_n_flag,
    input wire logic              full_n_flag,
    input wire logic              almost_empty_n_flag,
    input wire logic              almost_full_n_flag,
    input wire logic              load_mode
);
default clocking @(posedge clk); endclocking
default disable iff (!resetn);
wire push_take = wr_ready && !push_en_n && second_push_en_or_load;
sequence s_fill;
    !empty_n_flag && push_take;
endsequence
sequence s_first_pop;
    s_fill ##1 !pop_en_n;
endsequence
AST_OE: assert property (rd_data_oe_n == {DATA_W{out_en_n}})
    else $error("output enable mismatch");
AST_EMPTY_RISE: assert property (s_fill |=> empty_n_flag)
    else $error("empty flag did not rise");
AST_FIRST_WORD: assert property (s_first_pop |=> rd_data_o == $past(wr_data, 2))
    else $error("first word wrong");
AST_FULL_RISE: assert property (!full_n_flag && !pop_en_n && empty_n_flag |=> full_n_flag)
    else $error("full flag did not fall back");
AST_FULL_BLOCK: assert property (!full_n_flag |-> !wr_ready)
    else $error("ready while full");
AST_MODE: assert property ($rose(resetn) |=> load_mode == !$past(second_push_en_or_load))
    else $error("mode not captured");
AST_NO_TAKE: assert property (!empty_n_flag && !second_push_en_or_load && pop_en_n |=> !empty_n_flag)
    else $error("write taken with pin low");
AST_AF_FULL: assert property (!full_n_flag |-> !almost_full_n_flag)
    else $error("almost full high when full");
AST_AE_EMPTY: assert property (!empty_n_flag |-> !almost_empty_n_flag)
    else $error("almost empty high when empty");
AST_POP_EMPTY: assert property (!empty_n_flag |=> $stable(rd_data_o))
    else $error("data moved while empty");
endmodule // sfr_chk
bind sfr_top sfr_chk chk_i (.*);

// ==== sfr_reader_model.sv ====
// reader model that pops on request and keeps what came out
`timescale 1ns/1ps
module sfr_reader_model
    import sfr_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic              pop_req,
    input  wire logic              empty_n_flag,
    input  wire logic [DATA_W-1:0] rd_data_o,
    output logic                   pop_en_n,
    output logic [DATA_W-1:0]      last_word,
    output int                     n_got
);
logic took_q;
assign pop_en_n = !pop_req;
always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
        took_q <= 1'b0;
        n_got <= 0;
        last_word <= '0;
    end
    else
    begin
        // word is read the cycle after the pop is taken
        took_q <= pop_req && empty_n_flag;
        if (took_q)
        begin
            last_word <= rd_data_o;
            n_got <= n_got + 1;
        end
    end
endmodule // sfr_reader_model

// ==== sfr_top_bench.sv ====
// self-checking bench for the flagged fifo
`timescale 1ns/1ps
module sfr_top_bench
    import sfr_pkg::*;
;
logic clk = 0, resetn = 0, push_en_n = 1, second_push_en_or_load = 1, out_en_n = 0;
logic pop_req = 0, wr_ready, pop_en_n, empty_n_flag, full_n_flag;
logic almost_empty_n_flag, almost_full_n_flag, load_mode;
logic [DATA_W-1:0] wr_data = '0, rd_data_o, rd_data_oe_n, last_word;
int fails = 0, total_checks = 0, n_got, lvl, wseq, rseq, ae, af;
always #12.5 clk = ~clk;
sfr_top uut (.*);
sfr_reader_model peer (.*);
task automatic chk(string what, logic [8:0] seen, logic [8:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
        fails++;
        $display("Error %s expected %h seen %h", what, exp, seen);
    end
endtask
task automatic wrap_up;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
        $display("bench passed");
    else
        $display("bench failed");
    $finish;
endtask
task automatic do_reset(logic pin);
    @(negedge clk);
    resetn = 0;
    second_push_en_or_load = pin; // held through reset and first edge
    lvl = 0;
    wseq = 0;
    rseq = 0;
    ae = AE_OFF_RST;
    af = AF_OFF_RST;
    repeat (16) @(negedge clk);
    resetn = 1;
    repeat (2) @(negedge clk);
endtask
task automatic flags;
    logic [3:0] seen;
    logic [3:0] exp;
    seen = {empty_n_flag, full_n_flag, almost_empty_n_flag, almost_full_n_flag};
    exp = {lvl > 0, lvl < DEPTH, lvl >= ae, lvl <= DEPTH - af};
    chk("flags", 9'(seen), 9'(exp));
endtask
task automatic push(int n);
    for (int i = 0; i < n; i++)
    begin
        push_en_n = 0;
        wr_data = 9'(9'h100 + wseq);
        @(negedge clk);
        if (second_push_en_or_load && lvl < 16)
        begin
            lvl++;
            wseq++;
        end
        flags();
    end
    push_en_n = 1;
endtask
task automatic pop(int n);
    for (int i = 0; i < n; i++)
    begin
        pop_req = 1;
        @(negedge clk);
        if (lvl > 0)
        begin
            lvl--;
            rseq++;
        end
        chk("word", rd_data_o, 9'(9'h100 + rseq - 1));
        flags();
    end
    pop_req = 0;
endtask
task automatic t_reset_out;
    do_reset(1);
    chk("dout", rd_data_o, 9'h000);
    chk("oe", rd_data_oe_n, 9'h000);
    out_en_n = 1;
    @(negedge clk);
    chk("oe", rd_data_oe_n, 9'h1FF);
    out_en_n = 0;
    chk("mode", 9'(load_mode), 9'h000);
endtask
task automatic t_push_mode;
    second_push_en_or_load = 0;
    push(1);
    @(negedge clk);
    second_push_en_or_load = 1;
    push(1);
    pop(2);
    push(17);
    chk("ready", 9'(wr_ready), 9'h000);
    pop(17);
    @(negedge clk);
    chk("reader", 9'(n_got), 9'(wseq));
    chk("last", last_word, 9'(9'h100 + wseq - 1));
endtask
task automatic t_load_mode;
    do_reset(0);
    chk("mode", 9'(load_mode), 9'h001);
    push_en_n = 0;
    wr_data = 9'h004;
    @(negedge clk);
    wr_data = 9'h003;
    @(negedge clk);
    push_en_n = 1;
    ae = 4;
    af = 3;
    second_push_en_or_load = 1;
    @(negedge clk);
    flags();
    push(16);
    pop(16);
endtask
initial
begin
    t_reset_out();
    t_push_mode();
    t_load_mode();
    wrap_up();
end
initial
begin
    #50000;
    fails++;
    wrap_up();
end
endmodule // sfr_top_bench
